/* File: inc/spm_pkg.sv */
package spm_pkg;

  // Reference clock rate in kHz (40 ns period).
  localparam int unsigned CLK_KHZ         = 25000;
  // Enable filter time in microseconds, least time, rounded up.
  localparam int unsigned EN_FILTER_US    = 10;
  localparam int unsigned EN_FILTER_CYC   = (EN_FILTER_US * CLK_KHZ + 999) / 1000;
  // Activity monitor window in microseconds.
  localparam int unsigned MON_WINDOW_US   = 8;
  localparam int unsigned MON_WINDOW_CYC  = MON_WINDOW_US * CLK_KHZ / 1000;
  // Standby threshold in kHz and active threshold in kHz.
  localparam int unsigned STBY_KHZ        = 500;
  localparam int unsigned ACT_KHZ         = 3000;
  // Edge counts per window that match the thresholds.
  localparam int unsigned STBY_EDGES      = STBY_KHZ * MON_WINDOW_US / 1000;
  localparam int unsigned ACT_EDGES       = ACT_KHZ * MON_WINDOW_US / 1000;
  // Wake-up time for PLL lock in microseconds, longest time, rounded down.
  localparam int unsigned WAKEUP_US       = 100;
  localparam int unsigned WAKEUP_CYC      = WAKEUP_US * CLK_KHZ / 1000;
  // Line counter limit in lines.
  localparam int unsigned MAX_LINES       = 2046;

  // Counter widths.
  localparam int unsigned TMR_W           = 12;
  localparam int unsigned EDGE_W          = 8;
  localparam int unsigned LINE_W          = 12;

  // Operating modes of the block.
  typedef enum logic [2:0] {
    SPM_SHUTDOWN,
    SPM_STANDBY,
    SPM_ACQUIRE,
    SPM_TX_CLK_ON,
    SPM_TRANSMIT,
    SPM_OFF_CLK,
    SPM_OFF_DATA
  } spm_state_t;

  // Output stage controls, output enables are low while driving.
  typedef struct packed {
    logic clk_oe_b;
    logic dat_oe_b;
    logic pll_en;
    logic ser_en;
    logic mon_en;
  } spm_ctrl_t;

  // Camera input pins.
  typedef struct packed {
    logic       frame_sync;
    logic       line_sync;
    logic [7:0] data;
  } spm_cam_t;

endpackage : spm_pkg

/* File: verilog/spm_power_fsm.sv */
`timescale 1ns/1ps
module spm_power_fsm
  import spm_pkg::*;
(
  input  wire logic       clk_in,                 // Reference clock, 25 MHz.
  input  wire logic       rst_b_in,               // Synchronous reset, active low.
  input  wire logic       transmit_enable_pin_in, // Transmit enable pin.
  input  wire logic       pixel_clock_in,         // Pixel clock, sampled as a level.
  input  wire logic       freq_range_select_in,   // Pixel clock range select.
  input  wire logic       line_count_select_in,   // Line-count select.
  input  wire spm_cam_t   cam_in,                 // Frame sync, line sync, data.
  input  wire logic       pll_locked_in,          // PLL monitor reports stable lock.
  output spm_ctrl_t       ctrl_out,               // Output stage and power controls.
  output logic [7:0]      shift_data_out,         // Data latched on transmit entry.
  output logic            lock_timeout_out,       // Lock not reached in wake-up time.
  output logic            line_error_out,         // Line count above limit.
  output logic            range_high_out          // Registered range select.
);

  // Main state and its next value.
  spm_state_t       state_q, state_d;
  // Enable filter timer and filtered enable.
  logic [TMR_W-1:0] en_tmr_q, en_tmr_d;
  logic             en_ok_q, en_ok_d;
  // Monitor window timer, edge counter and its verdicts.
  logic [TMR_W-1:0] win_q, win_d;
  logic [EDGE_W-1:0] edges_q, edges_d;
  logic             active_q, active_d;
  logic             slow_q, slow_d;
  // Previous samples for edge detection.
  logic             pclk_prev_q, fs_prev_q, ls_prev_q;
  // Frame edge count in acquire, wake-up timer, line counter.
  logic [1:0]       fs_cnt_q, fs_cnt_d;
  logic [TMR_W-1:0] wake_q, wake_d;
  logic [LINE_W-1:0] lines_q, lines_d;
  // Registered outputs and their next values.
  spm_ctrl_t        ctrl_q, ctrl_d;
  logic [7:0]       shd_q, shd_d;
  logic             lto_q, lto_d;
  logic             lerr_q, lerr_d;
  logic             rng_q;

  // Edge strobes built from synchronous samples.
  logic pclk_rise, fs_rise, ls_fall;
  assign pclk_rise = pixel_clock_in & ~pclk_prev_q;
  assign fs_rise   = cam_in.frame_sync & ~fs_prev_q;
  assign ls_fall   = ~cam_in.line_sync & ls_prev_q;

  // Enable filter: the pin must hold a new level for the full filter time.
  always_comb begin
    en_tmr_d = en_tmr_q;
    en_ok_d  = en_ok_q;
    if (transmit_enable_pin_in == en_ok_q) begin
      en_tmr_d = '0;
    end else if (en_tmr_q >= TMR_W'(EN_FILTER_CYC - 1)) begin
      en_tmr_d = '0;
      en_ok_d  = transmit_enable_pin_in;
    end else begin
      en_tmr_d = en_tmr_q + TMR_W'(1);
    end
  end

  // Activity monitor: counts pixel clock edges per window.
  always_comb begin
    win_d    = win_q;
    edges_d  = edges_q;
    active_d = active_q;
    slow_d   = slow_q;
    if (!ctrl_q.mon_en) begin
      win_d    = '0;
      edges_d  = '0;
      active_d = 1'b0;
      slow_d   = 1'b1;
    end else if (win_q >= TMR_W'(MON_WINDOW_CYC - 1)) begin
      win_d    = '0;
      edges_d  = '0;
      active_d = edges_q > EDGE_W'(ACT_EDGES);
      slow_d   = edges_q < EDGE_W'(STBY_EDGES);
    end else begin
      win_d = win_q + TMR_W'(1);
      if (pclk_rise && edges_q != '1) begin
        edges_d = edges_q + EDGE_W'(1);
      end
    end
  end

  // Mode sequencer with output enable ordering.
  always_comb begin
    state_d  = state_q;
    fs_cnt_d = fs_cnt_q;
    wake_d   = wake_q;
    lines_d  = lines_q;
    shd_d    = shd_q;
    lto_d    = lto_q;
    lerr_d   = lerr_q;
    case (state_q)
      SPM_SHUTDOWN: begin
        if (en_ok_q) begin
          state_d = SPM_STANDBY;
        end
      end
      SPM_STANDBY: begin
        fs_cnt_d = '0;
        wake_d   = '0;
        lto_d    = 1'b0;
        if (!en_ok_q) begin
          state_d = SPM_OFF_CLK;
        end else if (active_q) begin
          state_d = SPM_ACQUIRE;
        end
      end
      SPM_ACQUIRE: begin
        if (!en_ok_q) begin
          state_d = SPM_SHUTDOWN;
        end else if (slow_q) begin
          state_d = SPM_STANDBY;
        end else if (!pll_locked_in) begin
          fs_cnt_d = '0;
          if (wake_q >= TMR_W'(WAKEUP_CYC - 1)) begin
            lto_d = 1'b1;
          end else begin
            wake_d = wake_q + TMR_W'(1);
          end
        end else if (fs_rise) begin
          lines_d = '0;
          if (!line_count_select_in || fs_cnt_q == 2'h1) begin
            state_d = SPM_TX_CLK_ON;
            shd_d   = cam_in.data;
          end else begin
            fs_cnt_d = fs_cnt_q + 2'h1;
          end
        end
      end
      SPM_TX_CLK_ON: begin
        state_d = SPM_TRANSMIT;
      end
      SPM_TRANSMIT: begin
        if (!en_ok_q) begin
          state_d = SPM_OFF_CLK;
        end else if (slow_q || !pll_locked_in) begin
          state_d = SPM_STANDBY;
        end else begin
          if (fs_rise) begin
            lines_d = '0;
          end else if (ls_fall && line_count_select_in) begin
            if (lines_q >= LINE_W'(MAX_LINES)) begin
              lerr_d = 1'b1;
            end else begin
              lines_d = lines_q + LINE_W'(1);
            end
          end
        end
      end
      SPM_OFF_CLK: begin
        state_d = SPM_OFF_DATA;
      end
      SPM_OFF_DATA: begin
        state_d = SPM_SHUTDOWN;
      end
      default: begin
        state_d = SPM_SHUTDOWN;
      end
    endcase
  end

  // Output controls follow the next state so they come from flip-flops.
  always_comb begin
    ctrl_d = '{clk_oe_b: 1'b1, dat_oe_b: 1'b1, pll_en: 1'b0, ser_en: 1'b0, mon_en: 1'b0};
    case (state_d)
      SPM_STANDBY:   ctrl_d.mon_en = 1'b1;
      SPM_ACQUIRE: begin
        ctrl_d.mon_en = 1'b1;
        ctrl_d.pll_en = 1'b1;
      end
      SPM_TX_CLK_ON: begin
        ctrl_d.mon_en   = 1'b1;
        ctrl_d.pll_en   = 1'b1;
        ctrl_d.ser_en   = 1'b1;
        ctrl_d.clk_oe_b = 1'b0;
      end
      SPM_TRANSMIT: begin
        ctrl_d.mon_en   = 1'b1;
        ctrl_d.pll_en   = 1'b1;
        ctrl_d.ser_en   = 1'b1;
        ctrl_d.clk_oe_b = 1'b0;
        ctrl_d.dat_oe_b = 1'b0;
      end
      SPM_OFF_CLK: begin
        ctrl_d.mon_en   = 1'b1;
        ctrl_d.pll_en   = ctrl_q.pll_en;
        ctrl_d.ser_en   = ctrl_q.ser_en;
        ctrl_d.dat_oe_b = ctrl_q.dat_oe_b;
      end
      SPM_OFF_DATA:  ctrl_d.mon_en = 1'b1;
      default:       ctrl_d.mon_en = 1'b0;
    endcase
  end

  // State registers; everything resets to shutdown with outputs off.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q     <= SPM_SHUTDOWN;
      en_tmr_q    <= '0;
      en_ok_q     <= 1'b0;
      win_q       <= '0;
      edges_q     <= '0;
      active_q    <= 1'b0;
      slow_q      <= 1'b1;
      pclk_prev_q <= 1'b0;
      fs_prev_q   <= 1'b0;
      ls_prev_q   <= 1'b0;
      fs_cnt_q    <= '0;
      wake_q      <= '0;
      lines_q     <= '0;
      ctrl_q      <= '{clk_oe_b: 1'b1, dat_oe_b: 1'b1, pll_en: 1'b0, ser_en: 1'b0,
                       mon_en: 1'b0};
      shd_q       <= 8'h00;
      lto_q       <= 1'b0;
      lerr_q      <= 1'b0;
      rng_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      en_tmr_q    <= en_tmr_d;
      en_ok_q     <= en_ok_d;
      win_q       <= win_d;
      edges_q     <= edges_d;
      active_q    <= active_d;
      slow_q      <= slow_d;
      pclk_prev_q <= pixel_clock_in;
      fs_prev_q   <= cam_in.frame_sync;
      ls_prev_q   <= cam_in.line_sync;
      fs_cnt_q    <= fs_cnt_d;
      wake_q      <= wake_d;
      lines_q     <= lines_d;
      ctrl_q      <= ctrl_d;
      shd_q       <= shd_d;
      lto_q       <= lto_d;
      lerr_q      <= lerr_d;
      rng_q       <= freq_range_select_in;
    end
  end

  // Outputs come straight from flip-flops.
  assign ctrl_out         = ctrl_q;
  assign shift_data_out   = shd_q;
  assign lock_timeout_out = lto_q;
  assign line_error_out   = lerr_q;
  assign range_high_out   = rng_q;

  // Clock output turns on one cycle before data output.
  clk_before_data_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(ctrl_q.dat_oe_b) |-> $past(ctrl_q.clk_oe_b) == 1'b0)
    else $error("Data output enabled without clock output first.");

  // On disable the clock stage goes off one cycle before the data stage.
  data_after_clk_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == SPM_OFF_CLK) |-> ctrl_q.clk_oe_b ##1 ctrl_q.dat_oe_b)
    else $error("Data stage not released after clock stage.");

  // Shutdown keeps every stage off.
  shutdown_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == SPM_SHUTDOWN) |-> ctrl_q.clk_oe_b && ctrl_q.dat_oe_b && !ctrl_q.pll_en
    && !ctrl_q.ser_en && !ctrl_q.mon_en)
    else $error("Stage running in shutdown.");

  // Standby runs only the monitor with outputs off.
  standby_outputs_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == SPM_STANDBY) |-> ctrl_q.clk_oe_b && ctrl_q.dat_oe_b && !ctrl_q.pll_en)
    else $error("Standby with active outputs or PLL.");

  // Acquire keeps outputs off with PLL enabled.
  acquire_pll_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == SPM_ACQUIRE) |-> ctrl_q.pll_en && ctrl_q.dat_oe_b && ctrl_q.clk_oe_b)
    else $error("Acquire state with wrong stage controls.");

  // Transmit entry only on a frame-sync rising edge with lock.
  tx_on_frame_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == SPM_ACQUIRE && state_d == SPM_TX_CLK_ON) |-> fs_rise && pll_locked_in)
    else $error("Transmit entered without frame edge and lock.");

  // With line-count select high one edge must already have been counted.
  two_edges_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == SPM_ACQUIRE && state_d == SPM_TX_CLK_ON && line_count_select_in)
    |-> fs_cnt_q == 2'h1)
    else $error("Transmit entered after one edge with select high.");

  // Transmit leaves to standby when the pixel clock goes slow.
  clock_loss_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == SPM_TRANSMIT && en_ok_q && slow_q) |=> state_q == SPM_STANDBY)
    else $error("Pixel clock loss did not return to standby.");

  // Shutdown to standby only with filtered enable high.
  leave_shutdown_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == SPM_SHUTDOWN && en_ok_q) |=> state_q == SPM_STANDBY && ctrl_q.mon_en)
    else $error("Shutdown exit wrong.");

endmodule : spm_power_fsm

/* File: bench/spm_cam_model.sv */
`timescale 1ns/1ps
// Camera sensor model: pixel clock, frame sync pulses and pixel data.
module spm_cam_model
  import spm_pkg::*;
(
  input  wire logic       clk_in,          // Reference clock.
  input  wire logic       run_in,          // Pixel clock runs while high.
  input  wire logic       frame_req_in,    // Pulse starts one frame sync pulse.
  input  wire logic       line_req_in,     // Pulse makes one line sync pulse.
  input  wire logic [7:0] data_in,         // Pixel data to present.
  output logic            pixel_clock_out, // Pixel clock, 6.25 MHz.
  output spm_cam_t        cam_out          // Sync and data pins.
);
  logic [1:0] div_q = 2'h0; // Pixel clock divider.
  logic [3:0] fs_q  = 4'h0; // Frame sync pulse length.
  logic       ls_q  = 1'b0; // Line sync, one cycle high per request.

  // The divider clears to zero when stopped, so the clock idles low.
  always_ff @(posedge clk_in) begin
    div_q <= run_in ? div_q + 2'h1 : 2'h0;
    fs_q  <= frame_req_in ? 4'hF : ((fs_q != 4'h0) ? fs_q - 4'h1 : 4'h0);
    ls_q  <= line_req_in;
  end

  assign pixel_clock_out = div_q[1];
  // Line sync pulses only on request, so the bench decides the line count.
  assign cam_out = {fs_q != 4'h0, ls_q, data_in};
endmodule : spm_cam_model

/* File: bench/spm_power_fsm_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the operating mode controller.
module spm_power_fsm_tb
  import spm_pkg::*;
;
  logic       clk_in    = 1'b0;  // Reference clock.
  logic       rst_b_in  = 1'b0;  // Reset, active low.
  logic       en_pin    = 1'b0;  // Transmit enable pin.
  logic       run       = 1'b0;  // Pixel clock on.
  logic       frame_req = 1'b0;  // Frame sync request.
  logic       line_req  = 1'b0;  // Line sync request.
  logic       freq_range_select      = 1'b0;  // Range select.
  logic       lcs       = 1'b0;  // Line-count select.
  logic       locked    = 1'b0;  // PLL lock status.
  logic [7:0] data      = 8'h00; // Pixel data.
  logic       pclk;              // Pixel clock from the model.
  spm_cam_t   cam;               // Camera pins from the model.
  spm_ctrl_t  ctrl;              // Output stage controls.
  logic [7:0] shift_data;        // Latched data.
  logic       lock_to;           // Lock timeout flag.
  logic       line_err;          // Line count error flag.
  logic       range_hi;          // Registered range select.
  int         n_mismatch = 0;    // Mismatches seen.
  int         n_tests    = 0;    // Comparisons made.

  spm_power_fsm spm_power_fsm_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .transmit_enable_pin_in(en_pin),
    .pixel_clock_in(pclk), .freq_range_select_in(freq_range_select), .line_count_select_in(lcs),
    .cam_in(cam), .pll_locked_in(locked), .ctrl_out(ctrl), .shift_data_out(shift_data),
    .lock_timeout_out(lock_to), .line_error_out(line_err), .range_high_out(range_hi));

  spm_cam_model spm_cam_model_i (
    .clk_in(clk_in), .run_in(run), .frame_req_in(frame_req), .line_req_in(line_req),
    .data_in(data),
    .pixel_clock_out(pclk), .cam_out(cam));

  // The clock toggles every half period of 20 ns.
  always #20 clk_in = ~clk_in;

  // Compares one value and records the outcome.
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Moves to just after the next rising edges, where outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  // Waits a bounded time for the masked controls to match.
  task automatic wait_ctrl(input logic [4:0] m, input logic [4:0] e, input int max,
                           output int used);
    used = 0;
    while ((ctrl & m) !== e && used < max) begin
      tick(1);
      used++;
    end
    check({3'h0, ctrl & m}, {3'h0, e}, "controls");
  endtask : wait_ctrl

  // Prints the counts and the verdict, then ends the run.
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // A short enable glitch is ignored, a long one leaves shutdown.
  task automatic t_enable();
    int used;
    check({3'h0, ctrl}, 8'h18, "reset controls");
    check(shift_data, 8'h00, "reset data");
    en_pin <= 1'b1;
    tick(100);
    en_pin <= 1'b0;
    tick(300);
    check({3'h0, ctrl}, 8'h18, "glitch ignored");
    en_pin <= 1'b1;
    wait_ctrl(5'h1F, 5'h19, 400, used);
    check({7'h00, used >= 249}, 8'h01, "enable filter time");
  endtask : t_enable

  // A stopped pixel clock holds standby; range select is registered.
  task automatic t_standby();
    tick(500);
    check({3'h0, ctrl}, 8'h19, "standby holds");
    freq_range_select <= 1'b1;
    tick(1);
    check({7'h00, range_hi}, 8'h01, "range set");
    freq_range_select <= 1'b0;
    tick(1);
    check({7'h00, range_hi}, 8'h00, "range clear");
  endtask : t_standby

  // A running pixel clock enters acquire with all outputs off.
  task automatic t_acquire();
    int used;
    run <= 1'b1;
    wait_ctrl(5'h1C, 5'h1C, 450, used);
  endtask : t_acquire

  // One frame sync pulse.
  task automatic frame();
    frame_req <= 1'b1;
    tick(1);
    frame_req <= 1'b0;
  endtask : frame

  // Frame start enters transmit: clock output first, then data output.
  task automatic t_to_tx(input logic [7:0] d);
    int used;
    frame();
    wait_ctrl(5'h18, 5'h08, 40, used);
    check(shift_data, d, "latched data");
    tick(1);
    check({3'h0, ctrl & 5'h1E}, 8'h06, "transmit controls");
  endtask : t_to_tx

  // Stopping the pixel clock in transmit returns to standby; lock stays up meanwhile.
  task automatic t_clock_loss();
    int used;
    run <= 1'b0;
    wait_ctrl(5'h1F, 5'h19, 450, used);
    locked <= 1'b0;
    tick(4);
    check({3'h0, ctrl}, 8'h19, "standby after loss");
    check({7'h00, lock_to}, 8'h00, "timeout clear");
  endtask : t_clock_loss

  // Without lock no frame edge moves on, and the timeout flag rises.
  task automatic t_lock_timeout();
    frame();
    tick(2400);
    check({7'h00, lock_to}, 8'h00, "lock wait");
    tick(200);
    check({3'h0, ctrl & 5'h1C}, 8'h1C, "stay acquire");
    check({7'h00, lock_to}, 8'h01, "lock timeout");
  endtask : t_lock_timeout

  // With line counting, the first frame edge only primes the counter.
  task automatic t_two_frames();
    locked <= 1'b1;
    data <= 8'h5A;
    tick(4);
    frame();
    tick(30);
    check({3'h0, ctrl & 5'h1C}, 8'h1C, "one edge waits");
    t_to_tx(8'h5A);
  endtask : t_two_frames

  // Sends n line sync pulses, then lets the last fall be counted.
  task automatic lines(input int n);
    repeat (n) begin
      line_req <= 1'b1;
      tick(1);
      line_req <= 1'b0;
      tick(1);
    end
    tick(2);
  endtask : lines

  // The full line count passes in transmit; one line more is an error.
  task automatic t_lines();
    lines(2046);
    check({7'h00, line_err}, 8'h00, "line limit");
    lines(1);
    check({7'h00, line_err}, 8'h01, "line overflow");
    check({3'h0, ctrl & 5'h1E}, 8'h06, "still transmit");
  endtask : t_lines

  // A reset in mid-run clears every flag and holds the outputs off.
  task automatic t_reset();
    rst_b_in <= 1'b0;
    tick(2);
    check({3'h0, ctrl}, 8'h18, "mid reset controls");
    check({6'h00, lock_to, line_err}, 8'h00, "mid reset flags");
    check(shift_data, 8'h00, "mid reset data");
    rst_b_in <= 1'b1;
    tick(2);
    check({3'h0, ctrl}, 8'h18, "after reset");
  endtask : t_reset

  // Disable turns the clock output off, then data, then shutdown.
  task automatic t_disable();
    int used;
    en_pin <= 1'b0;
    wait_ctrl(5'h18, 5'h10, 300, used);
    check({7'h00, used >= 249}, 8'h01, "disable filter");
    tick(1);
    check({3'h0, ctrl & 5'h18}, 8'h18, "data output off");
    wait_ctrl(5'h1F, 5'h18, 3, used);
  endtask : t_disable

  // Main sequence.
  initial begin
    tick(16);
    rst_b_in <= 1'b1;
    tick(1);
    t_enable();
    t_standby();
    t_acquire();
    locked <= 1'b1;
    data <= 8'hC3;
    tick(4);
    t_to_tx(8'hC3);
    t_clock_loss();
    lcs <= 1'b1;
    t_acquire();
    t_lock_timeout();
    t_two_frames();
    t_lines();
    t_disable();
    t_reset();
    end_sim();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : spm_power_fsm_tb
